// ===== include/stop_defs.svh
`ifndef STOP_DEFS_SVH
`define STOP_DEFS_SVH
`define STOP_CLK_HZ 20000000
`define STOP_WAKE_MS 600
`define STOP_WAKE_CYC ((`STOP_CLK_HZ / 1000) * `STOP_WAKE_MS)
`define STOP_US_CYC (`STOP_CLK_HZ / 1000000)
`define STOP_SEC_CYC `STOP_CLK_HZ
`define STOP_TMO_MIN 8'h05
`define STOP_TMO_MAX 8'hFF
`define STOP_TMO_RST 8'h0A
`define STOP_SLEEP_RST 1'b0
`define STOP_TARE_OFF 2'h0
`define STOP_TARE_REQ 2'h1
`define STOP_TARE_ON 2'h2
`define STOP_PW 32
`define STOP_TSW 32
`define STOP_LONG_DIGITS 4'h9
`define STOP_LIMIT_RST 32'h7FFF_FFFF
`define STOP_STAMP_MAX 32'h3B9A_C9FF
`endif

// ===== include/stop_pkg.sv
package stop_pkg;
   typedef enum logic [2:0] {
      STOP_AWAKE = 3'b001,
      STOP_ASLEEP = 3'b010,
      STOP_WAKING = 3'b100
   } stop_pwr_t;
   typedef logic [31:0] stop_press_t;
endpackage

// ===== include/stop_tick_if.sv
interface stop_tick_if;
   logic us_tick;
   logic sec_tick;
   modport src (output us_tick, output sec_tick);
   modport dst (input us_tick, input sec_tick);
endinterface

// ===== hdl/stop_tick_gen.sv
`include "stop_defs.svh"
module stop_tick_gen (
   input wire logic mclk,
   input wire logic reset,
   stop_tick_if.src ticks
);
   localparam int USC = `STOP_US_CYC;
   localparam int SC = `STOP_SEC_CYC;
   logic [4:0] us_cnt, next_us_cnt;
   logic [24:0] s_cnt, next_s_cnt;
   logic us_t, next_us_t, s_t, next_s_t;
   always_comb begin
      next_us_t = (us_cnt == 5'(USC - 1));
      next_us_cnt = next_us_t ? 5'h0 : 5'(us_cnt + 5'h1);
      next_s_t = (s_cnt == 25'(SC - 1));
      next_s_cnt = next_s_t ? 25'h0 : 25'(s_cnt + 25'h1);
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         us_cnt <= 5'h0;
         s_cnt <= 25'h0;
         us_t <= 1'b0;
         s_t <= 1'b0;
      end else begin
         us_cnt <= next_us_cnt;
         s_cnt <= next_s_cnt;
         us_t <= next_us_t;
         s_t <= next_s_t;
      end
   end
   assign ticks.us_tick = us_t;
   assign ticks.sec_tick = s_t;
endmodule

// ===== hdl/stop_tare.sv
`include "stop_defs.svh"
module stop_tare (
   input wire logic mclk,
   input wire logic reset,
   input wire logic tare_lockout,
   input wire logic tare_req,
   input wire logic wr_state,
   input wire logic [1:0] wr_state_val,
   input wire logic wr_value,
   input wire logic [31:0] wr_value_val,
   input wire logic rd_valid,
   input wire logic [31:0] rd_raw,
   output logic [1:0] tare_state,
   output logic [31:0] tare_value,
   output logic tared_valid,
   output logic [31:0] tared
);
   logic [1:0] next_state;
   logic [31:0] next_value;
   logic next_tv;
   logic [31:0] next_tared;
   always_comb begin
      next_state = tare_state;
      next_value = tare_value;
      if (wr_state && wr_state_val <= `STOP_TARE_ON)
         next_state = wr_state_val;
      if (wr_value)
         next_value = wr_value_val;
      if (!tare_lockout && tare_req)
         next_state = `STOP_TARE_REQ;
      if (tare_lockout && wr_state && wr_state_val == `STOP_TARE_REQ)
         next_state = tare_state;
      if (rd_valid && tare_state == `STOP_TARE_REQ) begin
         next_value = rd_raw;
         next_state = `STOP_TARE_ON;
      end
      next_tv = rd_valid;
      next_tared = rd_raw;
      if (rd_valid && tare_state == `STOP_TARE_ON)
         next_tared = 32'(rd_raw - tare_value);
      else if (rd_valid && tare_state == `STOP_TARE_REQ)
         next_tared = 32'h0000_0000;
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         tare_state <= `STOP_TARE_OFF;
         tare_value <= 32'h0000_0000;
         tared_valid <= 1'b0;
         tared <= 32'h0000_0000;
      end else begin
         tare_state <= next_state;
         tare_value <= next_value;
         tared_valid <= next_tv;
         tared <= next_tared;
      end
   end
endmodule

// ===== hdl/stop_core.sv
`include "stop_defs.svh"
// Notes on behaviour
// - Asleep unit wakes 0.6 s after any character on either port.
// - The waking character is dropped, never passed to commands.
// - Sleep after timeout seconds with no character on either port.
// - Sleep enable: 0 off, 1 on, reset 0; off means never sleep.
// - Display or continuous background mode blocks sleep.
// - Timeout accepts integers 5 to 255 only, reset 10.
// - Overpressure output high when reading exceeds limit.
// - Overpressure output low once reading falls below limit.
// - Tare state cleared to 0 at reset.
// - Tare request from state write 1 or contact toggle.
// - Next reading after request becomes tare value; state 2; subtract.
// - Tare state and value writes need one-shot write enable.
// - New request while tared captures fresh value.
// - Written tare value used; later request overwrites it.
// - Lockout 1 ignores tare requests; 0 honours them.
// - Stamp enable 1 appends microsecond stamp to replies.
// - Stamp spans integration midpoint to first reply character.
// - Long format pads stamp to 9 digits.
// - Write enable covers only the next command, then clears.
module stop_core (
   input wire logic mclk,
   input wire logic reset,
   input wire logic rx_char_a,
   input wire logic rx_char_b,
   input wire logic [7:0] rx_data_a,
   input wire logic [7:0] rx_data_b,
   input wire logic cmd_done,
   input wire logic cmd_write_enable,
   input wire logic wr_sleep_enable,
   input wire logic wr_sleep_timeout,
   input wire logic wr_tare_state,
   input wire logic wr_tare_value,
   input wire logic wr_limit,
   input wire logic wr_stamp_cfg,
   input wire logic [31:0] wr_data,
   input wire logic [1:0] background_task_mode,
   input wire logic tare_contact,
   input wire logic tare_lockout,
   input wire logic meas_valid,
   input wire logic [31:0] meas_pressure,
   input wire logic integ_mid,
   input wire logic reply_start,
   output logic asleep,
   output logic char_valid,
   output logic [7:0] char_data,
   output logic overpressure,
   output logic sleep_enable,
   output logic [7:0] sleep_timeout_seconds,
   output logic [31:0] overpressure_limit,
   output logic [1:0] tare_state,
   output logic [31:0] tare_value,
   output logic tared_valid,
   output logic [31:0] tared_pressure,
   output logic one_shot_write_enable,
   output logic time_stamp_enable,
   output logic long_output_format,
   output logic stamp_valid,
   output logic [31:0] stamp_us,
   output logic [3:0] stamp_digits
);
   // ==========================================
   // Time base
   // Microsecond and second enables shared by idle count and stamp
   stop_tick_if tk ();
   stop_tick_gen u_tick (
      .mclk(mclk),
      .reset(reset),
      .ticks(tk)
   );

   // ==========================================
   // Write enable and settings
   logic next_ewe;
   logic next_sen;
   logic [7:0] next_tmo;
   logic [31:0] next_lim;
   logic next_tse;
   logic next_lof;
   logic wr_ok;
   // Set wins when the enable command and command end coincide
   always_comb begin
      wr_ok = one_shot_write_enable;
      next_ewe = one_shot_write_enable;
      if (cmd_done)
         next_ewe = 1'b0;
      if (cmd_write_enable)
         next_ewe = 1'b1;
      next_sen = sleep_enable;
      next_tmo = sleep_timeout_seconds;
      next_lim = overpressure_limit;
      next_tse = time_stamp_enable;
      next_lof = long_output_format;
      // Out-of-range sleep enable and timeout values are dropped, old setting kept
      if (wr_ok && wr_sleep_enable && wr_data[31:1] == 31'h0)
         next_sen = wr_data[0];
      if (wr_ok && wr_sleep_timeout && wr_data[31:8] == 24'h0 && wr_data[7:0] >= `STOP_TMO_MIN)
         next_tmo = wr_data[7:0];
      if (wr_ok && wr_limit)
         next_lim = wr_data;
      if (wr_ok && wr_stamp_cfg) begin
         next_tse = wr_data[0];
         next_lof = wr_data[1];
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         one_shot_write_enable <= 1'b0;
         sleep_enable <= `STOP_SLEEP_RST;
         sleep_timeout_seconds <= `STOP_TMO_RST;
         overpressure_limit <= `STOP_LIMIT_RST;
         time_stamp_enable <= 1'b0;
         long_output_format <= 1'b0;
      end else begin
         one_shot_write_enable <= next_ewe;
         sleep_enable <= next_sen;
         sleep_timeout_seconds <= next_tmo;
         overpressure_limit <= next_lim;
         time_stamp_enable <= next_tse;
         long_output_format <= next_lof;
      end
   end

   // ==========================================
   // Sleep control
   localparam int WAKE = `STOP_WAKE_CYC;
   stop_pkg::stop_pwr_t pwr;
   stop_pkg::stop_pwr_t next_pwr;
   logic [7:0] idle_s;
   logic [7:0] next_idle_s;
   logic [23:0] wake_cnt;
   logic [23:0] next_wake_cnt;
   logic any_rx;
   logic bg_busy;
   logic next_asleep;
   logic next_cv;
   logic [7:0] next_cd;
   always_comb begin
      any_rx = rx_char_a | rx_char_b;
      bg_busy = |background_task_mode;
      next_pwr = pwr;
      next_idle_s = idle_s;
      next_wake_cnt = wake_cnt;
      next_cv = 1'b0;
      next_cd = char_data;
      unique case (pwr)
         stop_pkg::STOP_AWAKE: begin
            next_cv = any_rx;
            next_cd = rx_char_a ? rx_data_a : rx_data_b;
            // Free-running second tick: idle time may fall up to one second short
            if (any_rx || !sleep_enable || bg_busy)
               next_idle_s = 8'h0;
            else if (tk.sec_tick)
               next_idle_s = 8'(idle_s + 8'h1);
            if (sleep_enable && !bg_busy && !any_rx && idle_s >= sleep_timeout_seconds)
               next_pwr = stop_pkg::STOP_ASLEEP;
         end
         stop_pkg::STOP_ASLEEP: begin
            next_idle_s = 8'h0;
            if (any_rx) begin
               next_pwr = stop_pkg::STOP_WAKING;
               next_wake_cnt = 24'h0;
            end
         end
         stop_pkg::STOP_WAKING: begin
            next_wake_cnt = 24'(wake_cnt + 24'h1);
            if (wake_cnt == 24'(WAKE - 1))
               next_pwr = stop_pkg::STOP_AWAKE;
         end
         // Stray code after an upset falls back to awake
         default: begin
            next_pwr = stop_pkg::STOP_AWAKE;
            next_idle_s = 8'h0;
         end
      endcase
      next_asleep = (next_pwr != stop_pkg::STOP_AWAKE);
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         pwr <= stop_pkg::STOP_AWAKE;
         idle_s <= 8'h0;
         wake_cnt <= 24'h0;
         asleep <= 1'b0;
         char_valid <= 1'b0;
         char_data <= 8'h00;
      end else begin
         pwr <= next_pwr;
         idle_s <= next_idle_s;
         wake_cnt <= next_wake_cnt;
         asleep <= next_asleep;
         char_valid <= next_cv;
         char_data <= next_cd;
      end
   end

   // ==========================================
   // Overpressure
   logic next_op;
   always_comb begin
      next_op = overpressure;
      // Equal reading keeps the indicator where it was
      if (meas_valid && $signed(meas_pressure) > $signed(overpressure_limit))
         next_op = 1'b1;
      else if (meas_valid && $signed(meas_pressure) < $signed(overpressure_limit))
         next_op = 1'b0;
   end
   always_ff @(posedge mclk) begin
      if (reset)
         overpressure <= 1'b0;
      else
         overpressure <= next_op;
   end

   // ==========================================
   // Tare
   logic contact_q;
   logic next_contact_q;
   logic contact_edge;
   logic cmd_tare_req;
   logic tare_req;
   // Lockout and the refused state-1 write are applied in the tare unit
   always_comb begin
      next_contact_q = tare_contact;
      contact_edge = (tare_contact != contact_q);
      cmd_tare_req = wr_ok & wr_tare_state & (wr_data == 32'(`STOP_TARE_REQ));
      tare_req = contact_edge | cmd_tare_req;
   end
   // Follows the pin in reset too, so a closed contact gives no false toggle
   always_ff @(posedge mclk) begin
      if (reset)
         contact_q <= tare_contact;
      else
         contact_q <= next_contact_q;
   end
   stop_tare u_tare (
      .mclk(mclk),
      .reset(reset),
      .tare_lockout(tare_lockout),
      .tare_req(tare_req),
      .wr_state(wr_ok & wr_tare_state),
      .wr_state_val(wr_data[1:0]),
      .wr_value(wr_ok & wr_tare_value),
      .wr_value_val(wr_data),
      .rd_valid(meas_valid),
      .rd_raw(meas_pressure),
      .tare_state(tare_state),
      .tare_value(tare_value),
      .tared_valid(tared_valid),
      .tared(tared_pressure)
   );

   // ==========================================
   // Time stamp
   logic running;
   logic next_running;
   logic [31:0] us_cnt;
   logic [31:0] next_us_cnt;
   logic next_sv;
   logic [31:0] next_su;
   logic [3:0] next_sd;
   always_comb begin
      next_running = running;
      next_us_cnt = us_cnt;
      // Holds at the largest nine-digit value rather than wrapping
      if (running && tk.us_tick && us_cnt != `STOP_STAMP_MAX)
         next_us_cnt = 32'(us_cnt + 32'h1);
      if (integ_mid) begin
         next_running = 1'b1;
         next_us_cnt = 32'h0;
      end
      next_sv = 1'b0;
      next_su = stamp_us;
      next_sd = stamp_digits;
      // Captured as the first reply character starts
      if (reply_start && running) begin
         next_running = 1'b0;
         next_sv = time_stamp_enable;
         next_su = us_cnt;
         next_sd = long_output_format ? `STOP_LONG_DIGITS : 4'h0;
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         running <= 1'b0;
         us_cnt <= 32'h0;
         stamp_valid <= 1'b0;
         stamp_us <= 32'h0;
         stamp_digits <= 4'h0;
      end else begin
         running <= next_running;
         us_cnt <= next_us_cnt;
         stamp_valid <= next_sv;
         stamp_us <= next_su;
         stamp_digits <= next_sd;
      end
   end
endmodule

// ===== tb/stop_core_sva.sv
module stop_core_sva (
   input wire logic mclk,
   input wire logic reset,
   input wire logic rx_char_a,
   input wire logic rx_char_b,
   input wire logic [7:0] rx_data_a,
   input wire logic cmd_done,
   input wire logic cmd_write_enable,
   input wire logic wr_sleep_timeout,
   input wire logic wr_tare_state,
   input wire logic [1:0] background_task_mode,
   input wire logic tare_lockout,
   input wire logic meas_valid,
   input wire logic [31:0] meas_pressure,
   input wire logic asleep,
   input wire logic char_valid,
   input wire logic [7:0] char_data,
   input wire logic overpressure,
   input wire logic sleep_enable,
   input wire logic [7:0] sleep_timeout_seconds,
   input wire logic [31:0] overpressure_limit,
   input wire logic [1:0] tare_state,
   input wire logic [31:0] tare_value,
   input wire logic tared_valid,
   input wire logic one_shot_write_enable,
   input wire logic long_output_format,
   input wire logic stamp_valid,
   input wire logic [3:0] stamp_digits
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // ==========================================
   // Sleep and characters
   a_char_pass: assert property (rx_char_a && !rx_char_b && !asleep |=>
      char_valid && char_data == $past(rx_data_a))
      else $error("awake char not passed");
   a_wake_drop: assert property (asleep && (rx_char_a || rx_char_b) |=> !char_valid)
      else $error("waking char passed");
   a_sleep_off: assert property (!sleep_enable && !asleep |=> !asleep)
      else $error("slept while disabled");
   a_mode_awake: assert property (background_task_mode != 2'h0 && !asleep |=> !asleep)
      else $error("slept in background mode");
   a_tmo_range: assert property (sleep_timeout_seconds >= 8'h05)
      else $error("timeout below range");
   // ==========================================
   // Overpressure, tare, write enable, stamp
   a_over_high: assert property (meas_valid && $signed(meas_pressure) > $signed(overpressure_limit) |=>
      overpressure)
      else $error("overpressure not raised");
   a_over_low: assert property (meas_valid && $signed(meas_pressure) < $signed(overpressure_limit) |=>
      !overpressure)
      else $error("overpressure not dropped");
   a_tare_take: assert property (meas_valid && tare_state == 2'h1 && !wr_tare_state |=>
      tare_state == 2'h2 && tare_value == $past(meas_pressure) && tared_valid)
      else $error("tare capture wrong");
   a_lock_hold: assert property (tare_lockout && tare_state != 2'h1 && !wr_tare_state |=>
      tare_state == $past(tare_state))
      else $error("tare under lockout");
   a_wen_clear: assert property (cmd_done && !cmd_write_enable |=> !one_shot_write_enable)
      else $error("write enable kept");
   a_wen_need: assert property (wr_sleep_timeout && !one_shot_write_enable |=> $stable(sleep_timeout_seconds))
      else $error("write without enable");
   a_stamp_pad: assert property (stamp_valid |-> stamp_digits == ($past(long_output_format) ? 4'h9 : 4'h0))
      else $error("stamp padding wrong");
   c_tare: cover property (meas_valid && tare_state == 2'h1);
   c_over: cover property ($rose(overpressure));
   c_stamp: cover property (stamp_valid && long_output_format);
endmodule

// ===== tb/stop_host.sv
module stop_host (
   input wire logic mclk,
   output logic rx_char_a,
   output logic rx_char_b,
   output logic [7:0] rx_data_a,
   output logic [7:0] rx_data_b
);
   timeunit 1ns;
   timeprecision 1ns;
   parameter int WAKE_GAP = 12000000;
   initial begin
      rx_char_a = 1'b0;
      rx_char_b = 1'b0;
      rx_data_a = 8'h00;
      rx_data_b = 8'h00;
   end
   // Idle data shows the inverse of the last byte
   task automatic send(input logic port_b, input logic [7:0] data);
      @(posedge mclk);
      if (port_b) begin
         rx_char_b <= 1'b1;
         rx_data_b <= data;
      end else begin
         rx_char_a <= 1'b1;
         rx_data_a <= data;
      end
      @(posedge mclk);
      rx_char_a <= 1'b0;
      rx_char_b <= 1'b0;
      if (port_b) rx_data_b <= ~data;
      else rx_data_a <= ~data;
      #1;
   endtask
   // Wake a sleeping unit, then hold off before commands
   task automatic wake(input logic port_b);
      send(port_b, 8'h00);
      repeat (WAKE_GAP) @(posedge mclk);
   endtask
   function automatic int reply_bits(input int chars);
      return chars * 10;
   endfunction
endmodule

// ===== tb/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [10:0] ctl = 11'h000;
   logic cmd_done, cmd_write_enable, wr_sleep_enable, wr_sleep_timeout, wr_tare_state, wr_tare_value;
   logic wr_limit, wr_stamp_cfg, meas_valid, integ_mid, reply_start, rx_char_a, rx_char_b;
   logic [7:0] rx_data_a, rx_data_b, char_data, sleep_timeout_seconds;
   logic [31:0] wr_data = 32'h0000_0000;
   logic [31:0] meas_pressure = 32'h0000_0000;
   logic [1:0] background_task_mode = 2'h0;
   logic tare_contact = 1'b0;
   logic tare_lockout = 1'b0;
   logic asleep, char_valid, overpressure, sleep_enable, tared_valid, one_shot_write_enable;
   logic time_stamp_enable, long_output_format, stamp_valid;
   logic [31:0] overpressure_limit, tare_value, tared_pressure, stamp_us;
   logic [1:0] tare_state;
   logic [3:0] stamp_digits;
   int bad_count = 0;
   int checked = 0;
   assign {reply_start, integ_mid, meas_valid, wr_stamp_cfg, wr_limit, wr_tare_value, wr_tare_state,
      wr_sleep_timeout, wr_sleep_enable, cmd_write_enable, cmd_done} = ctl;
   always #25 mclk = ~mclk;
   stop_host host (.*);
   stop_core uut (.*);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("checks=%0d mismatches=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // One-cycle strobe on control bit i with data d
   task automatic pulse(input int i, input logic [31:0] d);
      @(posedge mclk);
      ctl[i] <= 1'b1;
      wr_data <= d;
      meas_pressure <= d;
      @(posedge mclk);
      ctl[i] <= 1'b0;
      #1;
   endtask
   task automatic wr(input int i, input logic [31:0] d);
      pulse(1, 32'h0000_0000);
      pulse(i, d);
   endtask
   initial begin
      repeat (5000) @(posedge mclk);
      bad_count++;
      conclude;
   end
   initial begin
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      #1;
      chk(sleep_enable, 32'h0000_0000);
      chk(sleep_timeout_seconds, 32'h0000_000A);
      chk(tare_state, 32'h0000_0000);
      chk(asleep, 32'h0000_0000);
      chk(one_shot_write_enable, 32'h0000_0000);
      chk(overpressure_limit, 32'h7FFF_FFFF);
      // ==========================================
      // Settings and write enable
      pulse(3, 32'h0000_0014);
      chk(sleep_timeout_seconds, 32'h0000_000A);
      wr(3, 32'h0000_0004);
      chk(one_shot_write_enable, 32'h0000_0001);
      chk(sleep_timeout_seconds, 32'h0000_000A);
      pulse(3, 32'h0000_00FF);
      chk(sleep_timeout_seconds, 32'h0000_00FF);
      pulse(0, 32'h0000_0000);
      chk(one_shot_write_enable, 32'h0000_0000);
      pulse(3, 32'h0000_0005);
      chk(sleep_timeout_seconds, 32'h0000_00FF);
      wr(2, 32'h0000_0002);
      chk(sleep_enable, 32'h0000_0000);
      wr(2, 32'h0000_0001);
      chk(sleep_enable, 32'h0000_0001);
      @(posedge mclk);
      background_task_mode <= 2'h3;
      host.send(1'b0, 8'h41);
      chk(char_data, 32'h0000_0041);
      host.send(1'b1, 8'h5A);
      chk(char_data, 32'h0000_005A);
      chk(char_valid, 32'h0000_0001);
      chk(asleep, 32'h0000_0000);
      // ==========================================
      // Overpressure and tare
      wr(6, 32'h0000_03E8);
      chk(overpressure_limit, 32'h0000_03E8);
      pulse(8, 32'h0000_03E9);
      chk(overpressure, 32'h0000_0001);
      pulse(8, 32'h0000_03E8);
      chk(overpressure, 32'h0000_0001);
      pulse(8, 32'h0000_03E7);
      chk(overpressure, 32'h0000_0000);
      wr(4, 32'h0000_0001);
      chk(tare_state, 32'h0000_0001);
      pulse(8, 32'h0000_01F4);
      chk(tare_state, 32'h0000_0002);
      chk(tare_value, 32'h0000_01F4);
      chk(tared_pressure, 32'h0000_0000);
      chk(tared_valid, 32'h0000_0001);
      pulse(8, 32'h0000_03E9);
      chk(tared_pressure, 32'h0000_01F5);
      chk(overpressure, 32'h0000_0001);
      wr(5, 32'h0000_0064);
      pulse(8, 32'h0000_03E9);
      chk(tared_pressure, 32'h0000_0385);
      @(posedge mclk);
      tare_contact <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk(tare_state, 32'h0000_0001);
      pulse(8, 32'h0000_012C);
      chk(tare_value, 32'h0000_012C);
      chk(tare_state, 32'h0000_0002);
      @(posedge mclk);
      tare_lockout <= 1'b1;
      tare_contact <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      chk(tare_state, 32'h0000_0002);
      wr(4, 32'h0000_0001);
      chk(tare_state, 32'h0000_0002);
      // ==========================================
      // Time stamp, 211 cycles reads as 10 us
      wr(7, 32'h0000_0003);
      chk(time_stamp_enable, 32'h0000_0001);
      chk(long_output_format, 32'h0000_0001);
      pulse(9, 32'h0000_0000);
      repeat (209) @(posedge mclk);
      pulse(10, 32'h0000_0000);
      chk(stamp_valid, 32'h0000_0001);
      chk(stamp_us, 32'h0000_000A);
      chk(stamp_digits, 32'h0000_0009);
      wr(7, 32'h0000_0000);
      pulse(9, 32'h0000_0000);
      pulse(10, 32'h0000_0000);
      chk(stamp_valid, 32'h0000_0000);
      conclude;
   end
endmodule
bind stop_core stop_core_sva chk_i (.*);
